// *** rtl/psb_sram_port.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// pipelined burst sram port, device side
module psb_sram_port
  import psb_pkg::*;
#(
  parameter int MEM_WORDS = 2 ** psb_pkg::PSB_ADDR_W
) (
  input wire logic clk, // system clock, rising edge active
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [psb_pkg::PSB_ADDR_W-1:0] address, // external word address
  input wire logic readNotWrite, // high read, low write, used at loads
  input wire logic advanceOrLoad, // low load, high advance
  input wire logic clockHoldN, // high blocks the edge
  input wire logic chipSelectFirstN, // first select, active low
  input wire logic chipSelectSecondN, // second select, active low
  input wire logic chipSelectHigh, // third select, active high
  input wire logic [psb_pkg::PSB_LANES-1:0] byteWriteStrobeN, // per lane, active low
  input wire logic burstOrderSelect, // low linear, high interleaved
  input wire logic outputEnableN, // asynchronous output enable, active low
  input wire logic [psb_pkg::PSB_DATA_W-1:0] dqIn, // data bus as seen at the pins
  output logic [psb_pkg::PSB_DATA_W-1:0] dqOut, // read data driven to the bus
  output logic dqOe // high while the port drives the bus
);

  import psb_pkg::*;

  localparam int IDX_W = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;

  // =====================================================================
  // storage and state
  logic [PSB_DATA_W-1:0] memArray [MEM_WORDS];
  psb_state_t st_ff;
  psb_state_t nxt_st;

  // =====================================================================
  // command buffer signals
  psb_cmd_t pushCmd;
  psb_cmd_t headCmd;
  logic pushValid;
  logic pushReady;
  logic headValid;
  logic popReady;
  logic [$bits(psb_cmd_t)-1:0] headBits;

  // =====================================================================
  // decoded inputs
  logic running;
  logic selected;
  logic [PSB_BURST_W-1:0] nxtCnt;
  logic [PSB_BURST_W-1:0] burstLow;
  logic [PSB_DATA_W-1:0] readWord;
  logic [IDX_W-1:0] headIdx;
  logic [IDX_W-1:0] wrIdx;

  // a held edge freezes every register, the buffer included
  assign running = ~clockHoldN;
  assign selected = ~chipSelectFirstN & ~chipSelectSecondN & chipSelectHigh;
  assign nxtCnt = st_ff.cnt + 1'b1;
  assign headIdx = IDX_W'(headCmd.addr);
  assign wrIdx = IDX_W'(st_ff.wrAddr);

  // low address bits of the next burst word
  always_comb
  begin
    if (burstOrderSelect)
    begin
      burstLow = st_ff.base[PSB_BURST_W-1:0] ^ nxtCnt;
    end
    else
    begin
      burstLow = st_ff.base[PSB_BURST_W-1:0] + nxtCnt;
    end
  end

  // =====================================================================
  // load and advance decode, feeding the command buffer
  always_comb
  begin
    pushValid = 1'b0;
    pushCmd.write = 1'b0;
    pushCmd.addr = address;
    pushCmd.strobeN = byteWriteStrobeN;
    if (running)
    begin
      if (!advanceOrLoad)
      begin
        pushValid = selected;
        pushCmd.write = ~readNotWrite;
      end
      else if (st_ff.burst != PSB_IDLE)
      begin
        // the direction input is not looked at while advancing
        pushValid = 1'b1;
        pushCmd.write = (st_ff.burst == PSB_WR_BURST);
        pushCmd.addr = {st_ff.base[PSB_ADDR_W-1:PSB_BURST_W], burstLow};
      end
    end
  end

  // =====================================================================
  // buffer between the input registers and the array access
  psb_pair_buf #(
    .WIDTH($bits(psb_cmd_t)),
    .DEPTH(PSB_BUF_DEPTH)
  ) u_cmd_buf (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushCmd),
    .outValid(headValid),
    .outReady(popReady),
    .outData(headBits)
  );

  assign headCmd = psb_cmd_t'(headBits);
  // the array stage drains only on live edges, and pushes are gated the same way, so a hold freezes the buffer
  assign popReady = running;

  // read with forwarding of the write committed on the same edge
  always_comb
  begin
    readWord = memArray[headIdx];
    if (st_ff.wrValid && (st_ff.wrAddr == headCmd.addr))
    begin
      for (int i = 0; i < PSB_LANES; i++)
      begin
        if (!st_ff.wrStrobeN[i])
        begin
          readWord[i*PSB_LANE_W +: PSB_LANE_W] = dqIn[i*PSB_LANE_W +: PSB_LANE_W];
        end
      end
    end
  end

  // =====================================================================
  // next state: burst tracking, array stage and output register
  always_comb
  begin
    nxt_st = st_ff;
    if (running)
    begin
      // burst bookkeeping follows the same decode as the buffer push
      if (!advanceOrLoad)
      begin
        case (st_ff.burst)
          PSB_IDLE, PSB_RD_BURST, PSB_WR_BURST:
          begin
            if (selected && pushReady)
            begin
              nxt_st.burst = readNotWrite ? PSB_RD_BURST : PSB_WR_BURST;
              nxt_st.base = address;
              nxt_st.cnt = PSB_CNT_RST;
            end
            else
            begin
              nxt_st.burst = PSB_IDLE;
            end
          end
          default:
          begin
            nxt_st.burst = PSB_IDLE;
          end
        endcase
      end
      else if ((st_ff.burst != PSB_IDLE) && pushReady)
      begin
        nxt_st.cnt = nxtCnt;
      end
      // the array stage takes the head of the buffer one edge after capture
      nxt_st.wrValid = headValid & headCmd.write;
      nxt_st.wrAddr = headCmd.addr;
      nxt_st.wrStrobeN = headCmd.strobeN;
      // an empty slot floats the bus two cycles after a deselect or no-op
      nxt_st.rdValid = headValid & ~headCmd.write;
      if (headValid && !headCmd.write)
      begin
        nxt_st.rdData = readWord;
      end
    end
  end

  // =====================================================================
  // state register; a held edge leaves nxt_st equal to st_ff
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_ff <= PSB_STATE_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================================
  // array write two cycles after the load, when the controller drives data
  always_ff @(posedge clk)
  begin
    if (rst_b && running && st_ff.wrValid)
    begin
      for (int i = 0; i < PSB_LANES; i++)
      begin
        if (!st_ff.wrStrobeN[i])
        begin
          memArray[wrIdx][i*PSB_LANE_W +: PSB_LANE_W] <= dqIn[i*PSB_LANE_W +: PSB_LANE_W];
        end
      end
    end
  end

  // =====================================================================
  // pins: data from the output register, enable gated without the clock
  assign dqOut = st_ff.rdData;
  // output enable is the one input that acts between edges
  assign dqOe = st_ff.rdValid & ~outputEnableN;

endmodule // psb_sram_port

`default_nettype wire

// *** rtl/psb_pkg.sv ***
// =====================================================================
// shared constants and carriers of the pipelined burst sram port
`default_nettype none

package psb_pkg;

  // =====================================================================
  // array geometry
  localparam int PSB_ADDR_W = 18; // word address width
  localparam int PSB_LANES = 4; // byte lanes per word
  localparam int PSB_LANE_W = 9; // eight data bits plus the parity lane bit
  localparam int PSB_DATA_W = PSB_LANES * PSB_LANE_W; // full word width
  localparam int PSB_BURST_W = 2; // burst counter steps the two low address bits

  // =====================================================================
  // pipeline shape
  localparam int PSB_LOAD_TO_DATA = 2; // cycles from a load to its data on the bus
  localparam int PSB_BUF_DEPTH = 2; // entries in the command buffer

  // =====================================================================
  // reset values
  localparam logic [PSB_BURST_W-1:0] PSB_CNT_RST = 2'h0;
  localparam logic [PSB_ADDR_W-1:0] PSB_ADDR_RST = 18'h00000;
  localparam logic [PSB_LANES-1:0] PSB_STROBE_N_RST = 4'hF;
  localparam logic [PSB_DATA_W-1:0] PSB_DATA_RST = 36'h000000000;

  // burst direction, held from the load that opened the burst
  typedef enum logic [2:0] {
    PSB_IDLE = 3'b001,
    PSB_RD_BURST = 3'b010,
    PSB_WR_BURST = 3'b100
  } psb_burst_t;

  // one memory operation travelling through the command buffer
  typedef struct packed {
    logic write;
    logic [PSB_ADDR_W-1:0] addr;
    logic [PSB_LANES-1:0] strobeN;
  } psb_cmd_t;

  // state of the port outside the array and the command buffer, registered as one word
  typedef struct packed {
    psb_burst_t burst;
    logic [PSB_ADDR_W-1:0] base;
    logic [PSB_BURST_W-1:0] cnt;
    logic wrValid;
    logic [PSB_ADDR_W-1:0] wrAddr;
    logic [PSB_LANES-1:0] wrStrobeN;
    logic rdValid;
    logic [PSB_DATA_W-1:0] rdData;
  } psb_state_t;

  localparam psb_state_t PSB_STATE_RST = '{
    burst: PSB_IDLE,
    base: PSB_ADDR_RST,
    cnt: PSB_CNT_RST,
    wrValid: 1'b0,
    wrAddr: PSB_ADDR_RST,
    wrStrobeN: PSB_STROBE_N_RST,
    rdValid: 1'b0,
    rdData: PSB_DATA_RST
  };

endpackage

`default_nettype wire

// *** rtl/psb_pair_buf.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// small fifo with valid and ready on both sides
module psb_pair_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic inValid, // filling side offers a word
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // word offered
  output logic outValid, // a word waits at the head
  input wire logic outReady, // draining side takes the head
  output logic [WIDTH-1:0] outData // head word
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] entry;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W:0] count;
  } psb_buf_state_t;

  psb_buf_state_t st_ff;
  psb_buf_state_t nxt_st;
  logic push;
  logic pop;

  // flags come from the occupancy count so full and empty never lie
  assign inReady = (st_ff.count != (PTR_W + 1)'(DEPTH));
  assign outValid = (st_ff.count != '0);
  assign outData = st_ff.entry[st_ff.rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // pointer stepping with wrap at the depth
  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.entry[st_ff.wrPtr] = inData;
      nxt_st.wrPtr = (st_ff.wrPtr == PTR_W'(DEPTH - 1)) ? '0 : st_ff.wrPtr + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rdPtr = (st_ff.rdPtr == PTR_W'(DEPTH - 1)) ? '0 : st_ff.rdPtr + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_st.count = st_ff.count + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  // entries need no reset: an empty count hides them
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_ff.rdPtr <= '0;
      st_ff.wrPtr <= '0;
      st_ff.count <= '0;
      st_ff.entry <= nxt_st.entry;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule // psb_pair_buf

`default_nettype wire

// *** verification/psb_sram_port_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// port-level properties of the burst sram port
module psb_sram_port_props
  import psb_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic readNotWrite, // direction
  input wire logic advanceOrLoad, // advance or load
  input wire logic clockHoldN, // edge hold
  input wire logic chipSelectFirstN, // select one
  input wire logic chipSelectSecondN, // select two
  input wire logic chipSelectHigh, // select three
  input wire logic outputEnableN, // output enable
  input wire logic [psb_pkg::PSB_DATA_W-1:0] dqOut, // read data
  input wire logic dqOe // bus drive
);
  logic sel;
  logic ld;
  // a load only counts on an edge that is not held
  assign sel = !chipSelectFirstN && !chipSelectSecondN && chipSelectHigh;
  assign ld = !clockHoldN && !advanceOrLoad;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // =====================================================================
  // assertions
  property p_oe_float; outputEnableN |-> !dqOe; endproperty
  a_oe_float: assert property (p_oe_float) else $error("bus driven with enable off");
  property p_rd_lat; (ld && sel && readNotWrite ##1 !clockHoldN ##1 !outputEnableN) |-> dqOe; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read word missing");
  property p_wr_float; (ld && sel && !readNotWrite ##1 !clockHoldN) |=> !dqOe; endproperty
  a_wr_float: assert property (p_wr_float) else $error("bus driven in write slot");
  property p_desel; (ld && !sel ##1 !clockHoldN) |=> !dqOe && $stable(dqOut); endproperty
  a_desel: assert property (p_desel) else $error("deselect moved the bus");
  property p_hold; (clockHoldN ##1 $stable(outputEnableN)) |-> $stable(dqOut) && $stable(dqOe); endproperty
  a_hold: assert property (p_hold) else $error("held edge changed outputs");
  property p_burst; (ld && sel && readNotWrite ##1 (advanceOrLoad && !clockHoldN) ##1 !clockHoldN
    ##1 !outputEnableN) |-> dqOe; endproperty
  a_burst: assert property (p_burst) else $error("burst word missing");
  property p_wburst; (ld && sel && !readNotWrite ##1 (advanceOrLoad && !clockHoldN) ##1 !clockHoldN)
    |=> !dqOe; endproperty
  a_wburst: assert property (p_wburst) else $error("write burst turned to read");
  property p_long; (ld && sel && readNotWrite ##1 (advanceOrLoad && !clockHoldN) [*5] ##1 !clockHoldN
    ##1 !outputEnableN) |-> dqOe; endproperty
  a_long: assert property (p_long) else $error("long burst stopped");
  c_burst: cover property (ld && sel && readNotWrite ##1 advanceOrLoad && !clockHoldN);
  c_hold: cover property (clockHoldN ##1 clockHoldN);
  c_desel: cover property (ld && !sel);
endmodule // psb_sram_port_props

bind psb_sram_port psb_sram_port_props i_props (.*);

`default_nettype wire

// *** verification/psb_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// memory controller on the far side of the port
module psb_ctl_model
  import psb_pkg::*;
(
  input wire logic clk, // clock
  input wire logic [psb_pkg::PSB_DATA_W-1:0] dqOut, // port read data
  input wire logic dqOe, // port drives the bus
  output var logic [psb_pkg::PSB_ADDR_W-1:0] address, // word address
  output var logic readNotWrite, // direction
  output var logic advanceOrLoad, // advance or load
  output var logic clockHoldN, // edge hold
  output var logic chipSelectFirstN, // select one
  output var logic chipSelectSecondN, // select two
  output var logic chipSelectHigh, // select three
  output var logic [psb_pkg::PSB_LANES-1:0] byteWriteStrobeN, // lane strobes
  output var logic burstOrderSelect, // burst order, linear unless the bench asks
  output var logic outputEnableN, // output enable
  output logic [psb_pkg::PSB_DATA_W-1:0] dqIn // resolved bus
);
  logic [PSB_DATA_W-1:0] wData;
  logic [PSB_DATA_W-1:0] lastBus = '0;
  logic wDrv;
  logic rnwLoad = 1'b1;
  logic interleave = 1'b0; // bench sets it for an interleaved burst
  // a released bus shows the inverse of its last level, so stale data cannot pass
  assign dqIn = wDrv ? wData : (dqOe ? dqOut : ~lastBus);
  always @(posedge clk) lastBus <= dqIn;

  // one bus cycle: 0 read load, 1 write load, 2 advance, 3..5 deselect, 6 held garbage
  task automatic cyc(input int k, input logic [PSB_ADDR_W-1:0] a, input logic [PSB_DATA_W-1:0] w,
    input logic [PSB_LANES-1:0] st, input logic oe);
    if (k < 2) rnwLoad = (k == 0);
    clockHoldN = (k == 6);
    advanceOrLoad = (k == 2);
    address = a;
    readNotWrite = (k == 2) ? !rnwLoad : (k != 1);
    chipSelectFirstN = (k == 3) || (k == 6);
    chipSelectSecondN = (k == 4);
    chipSelectHigh = (k != 5);
    byteWriteStrobeN = st;
    burstOrderSelect = interleave;
    outputEnableN = oe;
    wDrv = (w != '0);
    wData = w;
  endtask
endmodule // psb_ctl_model

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// self-checking bench of the burst sram port
module tb_top;
  import psb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [PSB_ADDR_W-1:0] address;
  logic rnw, adv, hold, cs1, cs2, csh, bord, oeN, dqOe;
  logic [PSB_LANES-1:0] bws;
  logic [PSB_DATA_W-1:0] dqIn, dqOut;
  logic [PSB_LANES-1:0] st = 4'h0;
  logic oe = 1'b0;
  int failures = 0;
  int compares = 0;

  psb_sram_port #(.MEM_WORDS(256)) i_dut (.clk(clk), .rst_b(rst_b), .address(address),
    .readNotWrite(rnw), .advanceOrLoad(adv), .clockHoldN(hold), .chipSelectFirstN(cs1),
    .chipSelectSecondN(cs2), .chipSelectHigh(csh), .byteWriteStrobeN(bws),
    .burstOrderSelect(bord), .outputEnableN(oeN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
  psb_ctl_model i_ctl (.clk(clk), .dqOut(dqOut), .dqOe(dqOe), .address(address),
    .readNotWrite(rnw), .advanceOrLoad(adv), .clockHoldN(hold), .chipSelectFirstN(cs1),
    .chipSelectSecondN(cs2), .chipSelectHigh(csh), .byteWriteStrobeN(bws),
    .burstOrderSelect(bord), .outputEnableN(oeN), .dqIn(dqIn));

  // 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [35:0] dat(input logic [7:0] a);
    return {28'hC3A5E71, a};
  endfunction

  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: bus shows %h, wanted %h", $time, got, exp);
    end
  endtask

  // one cycle; e and q say what the bus must carry during it
  task automatic cy(input int k, input logic [7:0] a, input logic [35:0] w, input logic e,
    input logic [35:0] q);
    i_ctl.cyc(k, 18'(a), w, st, oe);
    #49;
    chk({dqOe, e ? dqOut : 36'h0}, {e, e ? q : 36'h0});
    @(posedge clk);
    #1;
  endtask

  // burst write wrapping from 0x12, a load in the last word's cycle, then a lane write
  task automatic t_write;
    cy(1, 8'h12, 0, 0, 0);
    cy(2, 0, 0, 0, 0);
    cy(2, 0, dat(8'h12), 0, 0);
    cy(2, 0, dat(8'h13), 0, 0);
    cy(2, 0, dat(8'h10), 0, 0);
    cy(1, 8'h20, dat(8'h11), 0, 0);
    cy(3, 0, dat(8'h52), 0, 0);
    cy(3, 0, dat(8'h20), 0, 0);
    st = 4'hA;
    cy(1, 8'h20, 0, 0, 0);
    st = 4'h0;
    cy(3, 0, 0, 0, 0);
    cy(3, 0, ~dat(8'h20), 0, 0);
    $display("write test done");
  endtask

  // burst read from 0x11 running past the wrap, then a load on the last word
  task automatic t_read;
    cy(0, 8'h11, 0, 0, 0);
    cy(2, 0, 0, 0, 0);
    cy(2, 0, 0, 1, dat(8'h11));
    cy(2, 0, 0, 1, dat(8'h52));
    cy(2, 0, 0, 1, dat(8'h13));
    cy(2, 0, 0, 1, dat(8'h10));
    cy(0, 8'h20, 0, 1, dat(8'h11));
    cy(3, 0, 0, 1, dat(8'h52));
    cy(3, 0, 0, 1, dat(8'h20) ^ 36'h007FC01FF);
    cy(3, 0, 0, 0, 0);
    $display("read test done");
  endtask

  // every false select blocks a load; a write then read back to back
  task automatic t_select;
    for (int k = 3; k < 6; k++)
    begin
      cy(k, 8'h11, 0, 0, 0);
      cy(2, 0, 0, 0, 0);
    end
    cy(1, 8'h30, 0, 0, 0);
    cy(0, 8'h30, 0, 0, 0);
    cy(3, 0, dat(8'h30), 0, 0);
    cy(3, 0, 0, 1, dat(8'h30));
    cy(3, 0, 0, 0, 0);
    $display("select test done");
  endtask

  // held edges stretch a read and keep the word on the bus
  task automatic t_hold;
    cy(0, 8'h13, 0, 0, 0);
    cy(6, 8'h10, 0, 0, 0);
    cy(3, 0, 0, 0, 0);
    cy(6, 8'h10, 0, 1, dat(8'h13));
    cy(6, 8'h10, 0, 1, dat(8'h13));
    cy(3, 0, 0, 1, dat(8'h13));
    cy(3, 0, 0, 0, 0);
    $display("hold test done");
  endtask

  // output enable off floats a pending read word
  task automatic t_oe;
    cy(0, 8'h10, 0, 0, 0);
    cy(3, 0, 0, 0, 0);
    oe = 1'b1;
    cy(3, 0, 0, 0, 0);
    oe = 1'b0;
    cy(3, 0, 0, 0, 0);
    $display("enable test done");
  endtask

  // interleaved order from 0x11 walks 0x11, 0x10, 0x13, 0x12
  task automatic t_order;
    i_ctl.interleave = 1'b1;
    cy(0, 8'h11, 0, 0, 0);
    cy(2, 0, 0, 0, 0);
    cy(2, 0, 0, 1, dat(8'h11));
    cy(2, 0, 0, 1, dat(8'h10));
    cy(3, 0, 0, 1, dat(8'h13));
    cy(3, 0, 0, 1, dat(8'h52));
    cy(3, 0, 0, 0, 0);
    i_ctl.interleave = 1'b0;
    $display("order test done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hang is cut after far more cycles than the tests need
  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    i_ctl.cyc(3, 18'h0, 36'h0, 4'hF, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk({dqOe, dqOut}, 37'h0);
    t_write();
    t_read();
    t_select();
    t_hold();
    t_oe();
    t_order();
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
